// *** hdl/lpm_low_power_mode_controller.sv ***
// power state sequencer with clock, power and reset control over axi4-lite
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module lpm_low_power_mode_controller
#(
   parameter int DEEP_WAKE_CNT = lpm_pkg::DEEP_WAKE_CYCLES
)
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // axi4-lite slave
   input  wire logic [31:0]                 awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [31:0]                 araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   // processor and wake sources
   input  wire logic                        sleepReq,
   input  wire logic                        deepReq,
   input  wire logic                        periphIrq,
   input  wire logic                        subClkIrq,
   input  wire logic [12:0]                 gpioIrq,
   input  wire logic                        debugConnect,
   input  wire logic                        processorHang,
   input  wire logic                        lvdResetEvt,
   input  wire logic                        wdtResetEvt,
   // clock control
   output logic                             busClkEn,
   output logic                             sysClkEn,
   output logic                             mainClkEn,
   output logic [lpm_pkg::NPERIPH-1:0]      periphClkEn,
   output logic [lpm_pkg::NSUB-1:0]         subClkEn,
   output logic [2:0]                       clkSrcSel,
   output logic [3:0]                       sysClkDiv,
   output logic [3:0]                       periphClkDiv,
   // power and reset control
   output logic [1:0]                       sramPwrOn,
   output logic                             flashPwrOn,
   output logic                             rfPwrOn,
   output logic                             logicPwrOn,
   output logic [lpm_pkg::NPERIPH-1:0]      periphRst,
   output logic                             hangRst,
   output lpm_pkg::lpm_state_e              pmState,
   output logic                             irq
);
   import lpm_pkg::*;

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [31:0]      clkGate_q, autoStop_q, clkCfg_q, lockCfg_q, pwr_q;
   logic [31:0]      cause_q, stat_q, mask_q;
   logic [31:0]      clkGate_d, autoStop_d, clkCfg_d, lockCfg_d, pwr_d;
   logic [31:0]      cause_d, stat_d, mask_d;
   lpm_state_e       state_q, state_d;
   logic [WAKE_CNT_W-1:0] wakeCnt_q, wakeCnt_d;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire         wrGo   = awvalid && wvalid && !bvalid && !awready;
   wire         rdGo   = arvalid && !rvalid && !arready;
   wire [31:0]  wVal   = merge(32'h0000_0000, wdata, wstrb);
   wire         wGate  = wrGo && awaddr == ADDR_CLK_GATE;
   wire         wAuto  = wrGo && awaddr == ADDR_AUTO_STOP;
   wire         wCfg   = wrGo && awaddr == ADDR_CLK_CFG;
   wire         wPrst  = wrGo && awaddr == ADDR_PERIPH_RST;
   wire         wLock  = wrGo && awaddr == ADDR_PROCESSOR_HANG_STATE_CFG;
   wire         wPwr   = wrGo && awaddr == ADDR_SLEEP_PWR;
   wire         wCause = wrGo && awaddr == ADDR_RST_CAUSE;
   wire         wStat  = wrGo && awaddr == ADDR_IRQ_STAT;
   wire         wMask  = wrGo && awaddr == ADDR_IRQ_MASK;
   wire         wHit   = wGate | wAuto | wCfg | wPrst | wLock | wPwr | wCause | wStat | wMask;
   wire         rHit   = araddr inside {ADDR_CLK_GATE, ADDR_AUTO_STOP, ADDR_CLK_CFG,
                                        ADDR_PERIPH_RST, ADDR_PROCESSOR_HANG_STATE_CFG, ADDR_SLEEP_PWR,
                                        ADDR_RST_CAUSE, ADDR_IRQ_STAT, ADDR_IRQ_MASK};
   wire [31:0]  rVal   = araddr == ADDR_CLK_GATE   ? clkGate_q  :
                         araddr == ADDR_AUTO_STOP  ? autoStop_q :
                         araddr == ADDR_CLK_CFG    ? clkCfg_q   :
                         araddr == ADDR_PROCESSOR_HANG_STATE_CFG ? lockCfg_q  :
                         araddr == ADDR_SLEEP_PWR  ? pwr_q      :
                         araddr == ADDR_RST_CAUSE  ? cause_q    :
                         araddr == ADDR_IRQ_STAT   ? stat_q     :
                         araddr == ADDR_IRQ_MASK   ? mask_q     : 32'h0000_0000;

   // ****************************************************************
   // events
   // ****************************************************************
   wire         gpioWake  = |gpioIrq;
   wire         sleepWake = periphIrq | gpioWake | debugConnect;
   wire         deepWake  = subClkIrq | gpioWake | debugConnect;
   wire         hangEvt   = processorHang && !hangRst;
   wire         hangReset = hangEvt && lockCfg_q[HANG_RST_B];
   wire         enterSlp  = state_q == PM_ACTIVE && sleepReq;
   wire         isDeep    = state_q == PM_DEEP;
   wire         isSleep   = state_q == PM_SLEEP;
   wire [2:0]   evt;
   wire [2:0]   causeEvt;
   assign evt[EVT_WAKE]            = state_d == PM_WAKE && state_q != PM_WAKE;
   assign evt[EVT_PROCESSOR_HANG_STATE]          = hangEvt;
   assign evt[EVT_SLEEP]           = enterSlp;
   assign causeEvt[CAUSE_PROCESSOR_HANG_STATE]   = hangReset;
   assign causeEvt[CAUSE_LVD]      = lvdResetEvt;
   assign causeEvt[CAUSE_WDT]      = wdtResetEvt;

   // ****************************************************************
   // state sequencing
   // ****************************************************************
   always_comb
   begin
      state_d   = state_q;
      wakeCnt_d = wakeCnt_q;
      unique case (state_q)
         PM_ACTIVE:
         begin
            if (sleepReq)
               state_d = deepReq ? PM_DEEP : PM_SLEEP;
         end
         PM_SLEEP:
         begin
            if (sleepWake)
            begin
               state_d   = PM_WAKE;
               wakeCnt_d = WAKE_CNT_W'(SLEEP_WAKE_CYCLES);
            end
         end
         PM_DEEP:
         begin
            if (deepWake)
            begin
               state_d   = PM_WAKE;
               wakeCnt_d = WAKE_CNT_W'(DEEP_WAKE_CNT);
            end
         end
         PM_WAKE:
         begin
            wakeCnt_d = wakeCnt_q - WAKE_CNT_W'(1);
            if (wakeCnt_q <= WAKE_CNT_W'(1))
               state_d = PM_ACTIVE;
         end
      endcase
   end

   // ****************************************************************
   // register next values
   // ****************************************************************
   assign clkGate_d  = wGate ? merge(clkGate_q, wdata, wstrb) : clkGate_q;
   assign autoStop_d = wAuto ? merge(autoStop_q, wdata, wstrb) : autoStop_q;
   assign clkCfg_d   = wCfg ? merge(clkCfg_q, wdata, wstrb) : clkCfg_q;
   assign lockCfg_d  = wLock ? merge(lockCfg_q, wdata, wstrb) : lockCfg_q;
   assign pwr_d      = wPwr ? merge(pwr_q, wdata, wstrb) : pwr_q;
   assign mask_d     = wMask ? merge(mask_q, wdata, wstrb) : mask_q;
   assign cause_d    = (cause_q & ~(wCause ? wVal : 32'h0000_0000))
                       | {29'h0000_0000, causeEvt};
   assign stat_d     = (stat_q & ~(wStat ? wVal : 32'h0000_0000))
                       | {29'h0000_0000, evt};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q    <= PM_ACTIVE;
         wakeCnt_q  <= '0;
         clkGate_q  <= RST_CLK_GATE;
         autoStop_q <= RST_ZERO;
         clkCfg_q   <= RST_ZERO;
         lockCfg_q  <= RST_ZERO;
         pwr_q      <= RST_ZERO;
         cause_q    <= RST_ZERO;
         stat_q     <= RST_ZERO;
         mask_q     <= RST_ZERO;
      end
      else
      begin
         state_q    <= state_d;
         wakeCnt_q  <= wakeCnt_d;
         clkGate_q  <= clkGate_d;
         autoStop_q <= autoStop_d;
         clkCfg_q   <= clkCfg_d;
         lockCfg_q  <= lockCfg_d;
         pwr_q      <= pwr_d;
         cause_q    <= cause_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
      end
   end

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rresp   <= RESP_OKAY;
         rdata   <= 32'h0000_0000;
      end
      else
      begin
         awready <= wrGo;
         wready  <= wrGo;
         if (wrGo)
         begin
            bvalid <= 1'b1;
            bresp  <= wHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
         arready <= rdGo;
         if (rdGo)
         begin
            rvalid <= 1'b1;
            rresp  <= rHit ? RESP_OKAY : RESP_SLVERR;
            rdata  <= rVal;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // clock, power and reset outputs
   // ****************************************************************
   wire [NPERIPH-1:0] gateNow = isSleep ? clkGate_q[NPERIPH-1:0] & ~autoStop_q[NPERIPH-1:0]
                                        : clkGate_q[NPERIPH-1:0];
   wire               deepPwr = state_d == PM_DEEP;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busClkEn     <= 1'b1;
         sysClkEn     <= 1'b1;
         mainClkEn    <= 1'b1;
         periphClkEn  <= RST_CLK_GATE[NPERIPH-1:0];
         subClkEn     <= '1;
         clkSrcSel    <= SRC_FAST_RC;
         sysClkDiv    <= '0;
         periphClkDiv <= '0;
         sramPwrOn    <= '1;
         flashPwrOn   <= 1'b1;
         rfPwrOn      <= 1'b1;
         logicPwrOn   <= 1'b1;
         periphRst    <= '0;
         hangRst      <= 1'b0;
         irq          <= 1'b0;
         pmState      <= PM_ACTIVE;
      end
      else
      begin
         busClkEn     <= !(isSleep || isDeep);
         sysClkEn     <= !isDeep;
         mainClkEn    <= !isDeep;
         periphClkEn  <= isDeep ? '0 : gateNow;
         subClkEn     <= isDeep ? pwr_q[NSUB-1:0] : '1;
         clkSrcSel    <= clkCfg_q[SRC_HI:SRC_LO];
         sysClkDiv    <= clkCfg_q[SDIV_HI:SDIV_LO];
         periphClkDiv <= clkCfg_q[PDIV_HI:PDIV_LO];
         sramPwrOn    <= deepPwr ? ~pwr_q[SRAM_HI:SRAM_LO] : '1;
         flashPwrOn   <= !(deepPwr && pwr_q[FLASH_B]);
         rfPwrOn      <= !(deepPwr && pwr_q[RF_B]);
         logicPwrOn   <= !(deepPwr && pwr_q[LOGIC_B]);
         periphRst    <= wPrst ? wVal[NPERIPH-1:0] : '0;
         hangRst      <= hangReset;
         irq          <= |(stat_d & mask_d);
         pmState      <= state_d;
      end
   end
endmodule

// *** hdl/lpm_pkg.sv ***
// constants for the low power mode controller
package lpm_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [31:0] ADDR_CLK_GATE   = 32'h4005_0000;
   localparam logic [31:0] ADDR_AUTO_STOP  = 32'h4005_0004;
   localparam logic [31:0] ADDR_CLK_CFG    = 32'h4005_0008;
   localparam logic [31:0] ADDR_PERIPH_RST = 32'h4005_000C;
   localparam logic [31:0] ADDR_PROCESSOR_HANG_STATE_CFG = 32'h4005_0010;
   localparam logic [31:0] ADDR_SLEEP_PWR  = 32'h4005_0014;
   localparam logic [31:0] ADDR_RST_CAUSE  = 32'h4005_0018;
   localparam logic [31:0] ADDR_IRQ_STAT   = 32'h4005_001C;
   localparam logic [31:0] ADDR_IRQ_MASK   = 32'h4005_0020;

   // ****************************************************************
   // widths and fields
   // ****************************************************************
   localparam int NPERIPH = 16;
   localparam int NSUB    = 8;
   localparam int SRAM_LO = 8;
   localparam int SRAM_HI = 9;
   localparam int FLASH_B = 10;
   localparam int RF_B    = 11;
   localparam int LOGIC_B = 12;
   localparam int SRC_LO  = 0;
   localparam int SRC_HI  = 2;
   localparam int SDIV_LO = 4;
   localparam int SDIV_HI = 7;
   localparam int PDIV_LO = 8;
   localparam int PDIV_HI = 11;
   localparam int CAUSE_PROCESSOR_HANG_STATE = 0;
   localparam int CAUSE_LVD    = 1;
   localparam int CAUSE_WDT    = 2;
   localparam int EVT_WAKE     = 0;
   localparam int EVT_PROCESSOR_HANG_STATE   = 1;
   localparam int EVT_SLEEP    = 2;
   localparam int HANG_RST_B   = 0;

   // ****************************************************************
   // reset values and encodings
   // ****************************************************************
   localparam logic [31:0] RST_CLK_GATE  = 32'h0000_FFFF;
   localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
   localparam logic [2:0]  SRC_FAST_RC   = 3'h0;
   localparam logic [2:0]  SRC_RF        = 3'h1;
   localparam logic [2:0]  SRC_WATCH_XTAL = 3'h2;
   localparam logic [2:0]  SRC_SLOW_RC   = 3'h3;
   localparam logic [2:0]  SRC_PLL       = 3'h4;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS     = 5000;
   localparam int SLEEP_WAKE_NS     = 75;
   localparam int DEEP_WAKE_US      = 150;
   localparam int SLEEP_WAKE_CYCLES = (SLEEP_WAKE_NS * 1000) / CLK_PERIOD_PS;
   localparam int DEEP_WAKE_CYCLES  = (DEEP_WAKE_US * 1000000) / CLK_PERIOD_PS;
   localparam int WAKE_CNT_W        = 16;

   typedef enum logic [1:0]
   {
      PM_ACTIVE = 2'b00,
      PM_SLEEP  = 2'b01,
      PM_DEEP   = 2'b10,
      PM_WAKE   = 2'b11
   } lpm_state_e;
endpackage

// *** sim/lpm_checker.sv ***
// port assertions for the power sequencer
`timescale 1ns/100ps
module lpm_checker
(
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // core and wake
   input  wire logic                        sleepReq,
   input  wire logic                        deepReq,
   input  wire logic                        subClkIrq,
   input  wire logic [12:0]                 gpioIrq,
   // clocks, power, reset
   input  wire logic                        busClkEn,
   input  wire logic                        sysClkEn,
   input  wire logic                        mainClkEn,
   input  wire logic [lpm_pkg::NPERIPH-1:0] periphClkEn,
   input  wire logic [1:0]                  sramPwrOn,
   input  wire logic                        flashPwrOn,
   input  wire logic                        rfPwrOn,
   input  wire logic                        logicPwrOn,
   input  wire logic [lpm_pkg::NPERIPH-1:0] periphRst,
   input  wire lpm_pkg::lpm_state_e         pmState
);
   import lpm_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire pwrAll = &{sramPwrOn, flashPwrOn, rfPwrOn, logicPwrOn};
   wire lowSt = pmState == PM_SLEEP || pmState == PM_DEEP;
   wire actReq = pmState == PM_ACTIVE && sleepReq;
   chk_gate_deep_only: assert property (pmState != PM_DEEP |-> pwrAll)
      else $error("power gated outside deep power-down");
   chk_active_clocks: assert property (pmState == PM_ACTIVE |=> busClkEn && sysClkEn && mainClkEn)
      else $error("clock missing in active");
   chk_sleep_clocks: assert property (pmState == PM_SLEEP |=> !busClkEn && sysClkEn)
      else $error("wrong clocks in sleep");
   chk_deep_clocks: assert property (pmState == PM_DEEP |=> !(busClkEn | sysClkEn | mainClkEn) && periphClkEn == '0)
      else $error("clock running in deep power-down");
   chk_sleep_entry: assert property (actReq && !deepReq |=> pmState == PM_SLEEP)
      else $error("sleep not entered");
   chk_deep_entry: assert property (actReq && deepReq |=> pmState == PM_DEEP)
      else $error("deep power-down not entered");
   chk_gpio_wake: assert property (lowSt && gpioIrq != '0 |=> pmState == PM_WAKE)
      else $error("gpio did not wake");
   chk_sub_wake: assert property (pmState == PM_DEEP && subClkIrq |=> pmState == PM_WAKE)
      else $error("sub-clock interrupt did not wake");
   chk_wake_span: assert property (pmState == PM_SLEEP ##1 pmState == PM_WAKE |-> pmState == PM_WAKE [*8] ##[1:9] pmState == PM_ACTIVE)
      else $error("sleep wake span wrong");
   chk_rst_pulse: assert property (periphRst != '0 |=> periphRst == '0)
      else $error("peripheral reset not a pulse");
   cover property (pmState == PM_SLEEP ##1 pmState == PM_WAKE);
   cover property (pmState == PM_DEEP ##1 pmState == PM_WAKE);
   cover property (periphRst != '0);
endmodule
bind lpm_low_power_mode_controller lpm_checker lpm_checker_inst (.*);

// *** sim/lpm_core_model.sv ***
// behavioural processor core and wake sources
`timescale 1ns/100ps
module lpm_core_model
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // bench commands
   input  wire logic                 enterReq,
   input  wire logic                 enterDeep,
   input  wire logic                 wakeReq,
   input  wire logic [1:0]           wakeSrc,
   // controller state
   input  wire lpm_pkg::lpm_state_e  pmState,
   // core and wake outputs
   output logic                      sleepReq,
   output logic                      deepReq,
   output logic                      periphIrq,
   output logic                      subClkIrq,
   output logic                      debugConnect,
   output logic [12:0]               gpioIrq
);
   import lpm_pkg::*;
   // request held only while active, dropped before wake ends
   always_ff @(posedge clk)
   begin
      if (rst || pmState != PM_ACTIVE)
         {sleepReq, deepReq} <= 2'h0;
      else if (enterReq)
         {sleepReq, deepReq} <= {1'b1, enterDeep};
   end
   // wake levels held until the controller shows wake
   always_ff @(posedge clk)
   begin
      if (rst || pmState == PM_WAKE)
         {periphIrq, subClkIrq, debugConnect, gpioIrq} <= 16'h0000;
      else if (wakeReq)
      begin
         periphIrq <= wakeSrc == 2'h0;
         gpioIrq <= (wakeSrc == 2'h1) ? 13'h1000 : 13'h0000;
         debugConnect <= wakeSrc == 2'h2;
         subClkIrq <= wakeSrc == 2'h3;
      end
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the power sequencer
`timescale 1ns/100ps
module testbench;
   import lpm_pkg::*;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, sleepReq, deepReq, periphIrq, subClkIrq, debugConnect;
   logic processorHang, lvdResetEvt, wdtResetEvt, busClkEn, sysClkEn, mainClkEn;
   logic flashPwrOn, rfPwrOn, logicPwrOn, hangRst, irq, enterReq, enterDeep, wakeReq;
   logic [31:0] awaddr, wdata, araddr, rdata, bus;
   logic [15:0] periphClkEn, periphRst, seenRst;
   logic [12:0] gpioIrq;
   logic [7:0] subClkEn;
   logic [3:0] wstrb, sysClkDiv, periphClkDiv;
   logic [2:0] clkSrcSel;
   logic [1:0] bresp, rresp, resp, sramPwrOn, wakeSrc;
   logic seenHang;
   lpm_state_e pmState;
   int nMismatch, totalChecks;
   lpm_low_power_mode_controller #(.DEEP_WAKE_CNT(20)) lpm_low_power_mode_controller_inst (.*);
   lpm_core_model lpm_core_model_inst (.*);
   always #2.5 clk = ~clk;
   always @(posedge clk)
      {seenRst, seenHang} <= rst ? 17'h0 : {seenRst | periphRst, seenHang | hangRst};
   // ****************************************************************
   // bus cycles and helpers
   // ****************************************************************
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      totalChecks++;
      if (g !== e)
      begin
         nMismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic pa, pw, pb;
      int n;
      {pa, pw, pb, n} = {3'b111, 32'h0};
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      while ((pa | pw | pb) && n++ < 99)
      begin
         @(posedge clk);
         pa = pa & !awready;
         pw = pw & !wready;
         if (pb && bvalid) resp = bresp;
         pb = pb & !bvalid;
         {awvalid, wvalid, bready} <= {pa, pw, pb};
      end
      if (pa | pw | pb)
         nMismatch++;
      @(posedge clk);
   endtask
   task automatic rd(input logic [31:0] a);
      logic pa, pr;
      int n;
      {pa, pr, n} = {2'b11, 32'h0};
      {araddr, arvalid, rready} <= {a, 2'b11};
      while ((pa | pr) && n++ < 99)
      begin
         @(posedge clk);
         pa = pa & !arready;
         if (pr && rvalid) {resp, bus} = {rresp, rdata};
         pr = pr & !rvalid;
         {arvalid, rready} <= {pa, pr};
      end
      if (pa | pr)
         nMismatch++;
      @(posedge clk);
   endtask
   task automatic waitst(input lpm_state_e s);
      int n;
      n = 0;
      while (pmState !== s && n++ < 500) @(posedge clk);
      cmp(pmState, s);
   endtask
   task automatic cue(input logic w, input logic [1:0] v);
      {enterDeep, wakeSrc} <= {v[0], v};
      if (w) wakeReq <= 1'b1; else enterReq <= 1'b1;
      @(posedge clk);
      {enterReq, wakeReq} <= 2'b00;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs;
      rd(ADDR_CLK_GATE);
      cmp(bus, RST_CLK_GATE);
      rd(ADDR_SLEEP_PWR);
      cmp(bus, RST_ZERO);
      wr(ADDR_SLEEP_PWR, 32'h0000_1F05);
      rd(ADDR_SLEEP_PWR);
      cmp(bus, 32'h0000_1F05);
      wstrb <= 4'h1;
      wr(ADDR_SLEEP_PWR, 32'h0000_00AA);
      wstrb <= 4'hF;
      rd(ADDR_SLEEP_PWR);
      cmp(bus, 32'h0000_1FAA);
      rd(32'h4005_0024);
      cmp(resp, RESP_SLVERR);
      cmp(bus, 32'h0);
      wr(32'h4005_0100, 32'h0000_0001);
      cmp(resp, RESP_SLVERR);
   endtask
   task automatic t_clk;
      logic [31:0] v;
      logic [2:0] src [5] = '{SRC_FAST_RC, SRC_RF, SRC_WATCH_XTAL, SRC_SLOW_RC, SRC_PLL};
      for (int i = 0; i < 5; i++)
      begin
         v = {20'h0, 4'(i + 3), 4'(9 - i), 1'b0, src[i]};
         wr(ADDR_CLK_CFG, v);
         cmp({periphClkDiv, sysClkDiv, 1'b0, clkSrcSel}, v);
      end
   endtask
   task automatic t_sleep;
      wr(ADDR_CLK_GATE, 32'h0000_00FF);
      cmp(periphClkEn, 16'h00FF);
      wr(ADDR_AUTO_STOP, 32'h0000_000F);
      cue(1'b0, 2'h0);
      waitst(PM_SLEEP);
      cmp({sramPwrOn, flashPwrOn, rfPwrOn, logicPwrOn}, 5'h1F);
      repeat (2) @(posedge clk);
      cmp({busClkEn, sysClkEn}, 2'b01);
      cmp(periphClkEn, 16'h00F0);
      cue(1'b1, 2'h0);
      waitst(PM_WAKE);
      waitst(PM_ACTIVE);
   endtask
   task automatic t_deep;
      logic [31:0] pv [3] = '{32'h0000_1F05, 32'h0000_0A5A, 32'h0000_1500};
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_SLEEP_PWR, pv[i]);
         cue(1'b0, 2'h1);
         waitst(PM_DEEP);
         cmp({logicPwrOn, rfPwrOn, flashPwrOn, sramPwrOn}, 5'(~pv[i][12:8]));
         repeat (2) @(posedge clk);
         cmp(subClkEn, pv[i][7:0]);
         cmp({mainClkEn, busClkEn, sysClkEn, periphClkEn}, 19'h0);
         cue(1'b1, 2'(i + 1));
         waitst(PM_WAKE);
         cmp({sramPwrOn, flashPwrOn, rfPwrOn, logicPwrOn}, 5'h1F);
         waitst(PM_ACTIVE);
      end
   endtask
   task automatic t_rst;
      wr(ADDR_PERIPH_RST, 32'h0000_8001);
      cmp(seenRst, 16'h8001);
      rd(ADDR_PERIPH_RST);
      cmp(bus, RST_ZERO);
      processorHang <= 1'b1;
      @(posedge clk);
      processorHang <= 1'b0;
      repeat (2) @(posedge clk);
      cmp(seenHang, 1'b0);
      wr(ADDR_PROCESSOR_HANG_STATE_CFG, 32'h0000_0001);
      processorHang <= 1'b1;
      @(posedge clk);
      {processorHang, lvdResetEvt} <= 2'b01;
      @(posedge clk);
      {lvdResetEvt, wdtResetEvt} <= 2'b01;
      @(posedge clk);
      wdtResetEvt <= 1'b0;
      rd(ADDR_RST_CAUSE);
      cmp(seenHang, 1'b1);
      cmp(bus, 32'h7);
      wr(ADDR_RST_CAUSE, 32'h0000_0007);
      rd(ADDR_RST_CAUSE);
      cmp(bus, RST_ZERO);
   endtask
   task automatic t_irq;
      rd(ADDR_IRQ_STAT);
      cmp(irq, 1'b0);
      cmp(bus, 32'h7);
      wr(ADDR_IRQ_MASK, 32'h0000_0004);
      cmp(irq, 1'b1);
      wr(ADDR_IRQ_STAT, 32'h0000_0004);
      cmp(irq, 1'b0);
      rd(ADDR_IRQ_STAT);
      cmp(bus, 32'h3);
   endtask
   task endSim;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      {clk, rst, awvalid, wvalid, bready, arvalid, rready, processorHang} = 8'h01 << 6;
      {lvdResetEvt, wdtResetEvt, enterReq, enterDeep, wakeReq, wakeSrc} = 7'h0;
      {awaddr, wdata, araddr, wstrb} = {96'h0, 4'hF};
      {nMismatch, totalChecks} = 64'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_clk();
      t_sleep();
      t_deep();
      t_rst();
      t_irq();
      endSim();
   end
   initial
   begin
      #100000;
      nMismatch++;
      endSim();
   end
endmodule
